// file: bench/scr_config_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module scr_config_regs_bench
  import scr_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       scl = 1'b1;
  logic       tb_sda = 1'b1;
  logic [1:0] emph_pin = 2'h0;
  logic       line_code_pin = 1'b0;
  wire logic  sda_line;
  logic       sda_out;
  logic       sda_oe_n;
  logic [2:0] general_output_values;
  scr_cfg_s   cfg_out;
  integer     seed = 32'haa61;
  int         bad_count = 0;
  int         total_checks = 0;
  logic       last_ack;
  logic [7:0] m06 = 8'h00;
  logic [7:0] m20 = 8'h00;
  logic [7:0] m21 = 8'h00;
  logic [7:0] rd;
  logic [7:0] ra;
  logic [7:0] apool [8] = '{8'h06, 8'h20, 8'h21, 8'h07, 8'h1F, 8'h22, 8'hFF, 8'h00};

  // The pull-up wins unless either party pulls the line low.
  assign sda_line = tb_sda & (sda_oe_n | sda_out);

  always #10 mclk = ~mclk;

  scr_config_regs i_dut
  (
    .mclk          (mclk),
    .rst           (rst),
    .scl           (scl),
    .sda_in        (sda_line),
    .sda_out       (sda_out),
    .sda_oe_n      (sda_oe_n),
    .emph_pin      (emph_pin),
    .line_code_pin (line_code_pin),
    .general_output_values        (general_output_values),
    .cfg_out       (cfg_out)
  );

  function automatic logic [7:0] model_rd(input logic [7:0] a);
    model_rd = (a == SCR_ADDR_GPOUT) ? m06 : (a == SCR_ADDR_EMPH) ? m20 :
               (a == SCR_ADDR_LINE) ? m21 : 8'h00;
  endfunction

  function automatic scr_cfg_s exp_cfg();
    exp_cfg.emph_level = scr_emph_e'(m20[2] ? m20[1:0] : emph_pin);
    exp_cfg.nrzi_en = m20[2] ? m21[7] : line_code_pin;
    exp_cfg.valid_marker_on = ~m21[6];
  endfunction

  task automatic model_wr(input logic [7:0] a, input logic [7:0] d);
    if (a == SCR_ADDR_GPOUT) m06 = d & 8'h07;
    if (a == SCR_ADDR_EMPH) m20 = d & 8'h07;
    if (a == SCR_ADDR_LINE) m21 = d & 8'hC0;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Phases of 8 cycles leave room for the two-flop pin synchronisers.
  task automatic sbit(input logic b);
    tick(4); tb_sda = b; tick(4); scl = 1'b1; tick(8); scl = 1'b0;
  endtask

  task automatic rbit(output logic b);
    tick(4); tb_sda = 1'b1; tick(4); scl = 1'b1; tick(4); b = sda_line; tick(4); scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) sbit(d[i]);
    rbit(last_ack);
  endtask

  task automatic rbyte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    sbit(1'b1);
  endtask

  task automatic bstart();
    tb_sda = 1'b1; tick(4); scl = 1'b1; tick(8); tb_sda = 1'b0; tick(8); scl = 1'b0;
  endtask

  task automatic bstop();
    tick(4); tb_sda = 1'b0; tick(4); scl = 1'b1; tick(8); tb_sda = 1'b1; tick(8);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    bstart(); wbyte({SCR_DEV_ADDR, 1'b0}); wbyte(a); wbyte(d); bstop();
    model_wr(a, d);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    bstart(); wbyte({SCR_DEV_ADDR, 1'b0}); wbyte(a);
    bstart(); wbyte({SCR_DEV_ADDR, 1'b1}); rbyte(d); bstop();
  endtask

  task automatic outs();
    chk({5'h0, general_output_values}, m06, "general_output_values");
    chk({4'h0, cfg_out}, {4'h0, exp_cfg()}, "cfg_out");
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    tick(20);
    outs();
    rst = 1'b0;
    tick(4);
    for (int i = 0; i < 4; i++)
    begin
      emph_pin = 2'(~i);
      wreg(SCR_ADDR_EMPH, 8'h04 | 8'(i));
      chk({6'h0, cfg_out.emph_level}, 8'(i), "level code");
    end
    $display("test levels done");
    line_code_pin = 1'b0;
    wreg(SCR_ADDR_LINE, 8'h80);
    outs();
    wreg(SCR_ADDR_EMPH, 8'h00);
    outs();
    wreg(SCR_ADDR_LINE, 8'h40);
    outs();
    $display("test line coding done");
    bstart(); wbyte({SCR_DEV_ADDR, 1'b0}); wbyte(SCR_ADDR_EMPH);
    wbyte(8'hFF); wbyte(8'hFF); bstop();
    model_wr(SCR_ADDR_EMPH, 8'hFF);
    model_wr(SCR_ADDR_LINE, 8'hFF);
    rreg(SCR_ADDR_EMPH, rd);
    chk(rd, m20, "emph readback");
    rreg(SCR_ADDR_LINE, rd);
    chk(rd, m21, "line readback");
    outs();
    $display("test burst done");
    bstart(); wbyte({SCR_DEV_ADDR ^ 7'h01, 1'b0});
    chk({7'h0, last_ack}, 8'h01, "foreign address acked");
    wbyte(SCR_ADDR_GPOUT); wbyte(8'hFF); bstop();
    outs();
    $display("test foreign address done");
    repeat (30)
    begin
      emph_pin = 2'($random(seed));
      line_code_pin = 1'($random(seed));
      wreg(apool[3'($random(seed))], 8'($random(seed)));
      outs();
      ra = apool[3'($random(seed))];
      rreg(ra, rd);
      chk(rd, model_rd(ra), "random readback");
    end
    for (int i = 0; i < 8; i++)
    begin
      rreg(apool[i], rd);
      chk(rd, model_rd(apool[i]), "readback");
    end
    $display("test random done");
    end_sim();
  end

  // About twice the expected run length.
  initial
  begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire

// file: logic/scr_config_regs.sv
// Operation
// - GPIO output pins follow output register bits.
// - Override bit selects register over pin configuration.
// - Level code: none, low, medium, high.
// - Line-coding bit acts only under override.
// - Bit six set turns data-valid signalling off.
`timescale 1ns/1ns
`default_nettype none
module scr_config_regs
  import scr_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rst,
  // Management bus pins.
  input  wire logic              scl,
  input  wire logic              sda_in,
  output var  logic              sda_out,
  output var  logic              sda_oe_n,
  // Configuration pins.
  input  wire logic [SCR_LVL_W-1:0] emph_pin,
  input  wire logic              line_code_pin,
  // Outputs to the serializer.
  output var  logic [SCR_GP_W-1:0] general_output_values,
  output var  scr_cfg_s          cfg_out
);

  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= SCR_ADDR_RSV_LO) && (a <= SCR_ADDR_RSV_HI);
  endfunction

  logic [4:0] pins_s;
  scr_sync #(.W(5)) u_sync
  (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({scl, sda_in, emph_pin, line_code_pin}),
    .sync_out (pins_s)
  );

  logic                 scl_s;
  logic                 sda_s;
  logic [SCR_LVL_W-1:0] emph_pin_s;
  logic                 line_pin_s;
  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign emph_pin_s = pins_s[2:1];
  assign line_pin_s = pins_s[0];

  // Bus engine state.
  scr_st_e    st;
  scr_st_e    next_st;
  logic [3:0] bcnt;
  logic [3:0] next_bcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txb;
  logic [7:0] next_txb;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       first;
  logic       next_first;
  logic       rd_mode;
  logic       next_rd_mode;
  logic       cont;
  logic       next_cont;
  logic       next_oe_n;
  logic       p_scl;
  logic       p_sda;
  logic       wr_pulse;
  logic [7:0] rd_data;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s && !p_scl;
  assign scl_fall = !scl_s && p_scl;
  assign start_c = scl_s && p_scl && !sda_s && p_sda;
  assign stop_c = scl_s && p_scl && sda_s && !p_sda;

  // Register state.
  logic      gp_unused;
  logic      ovr;
  logic      next_ovr;
  scr_emph_e lvl;
  scr_emph_e next_lvl;
  logic      nrzi_bit;
  logic      next_nrzi_bit;
  logic      dv_off;
  logic      next_dv_off;
  logic [SCR_GP_W-1:0] next_general_output_values;
  scr_cfg_s  next_cfg;

  always_comb
  begin
    rd_data = SCR_RST_BYTE;
    case (ptr)
      SCR_ADDR_GPOUT: rd_data[SCR_GP_W-1:0] = general_output_values;
      SCR_ADDR_EMPH:
      begin
        rd_data[SCR_BIT_OVERRIDE] = ovr;
        rd_data[SCR_LVL_LSB +: SCR_LVL_W] = lvl;
      end
      SCR_ADDR_LINE:
      begin
        rd_data[SCR_BIT_NRZI] = nrzi_bit;
        rd_data[SCR_BIT_DVOFF] = dv_off;
      end
      default: rd_data = SCR_RST_BYTE;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_txb = txb;
    next_ptr = ptr;
    next_first = first;
    next_rd_mode = rd_mode;
    next_cont = cont;
    next_oe_n = sda_oe_n;
    wr_pulse = 1'b0;
    if (start_c)
    begin
      next_st = SCR_ST_ADDR;
      next_bcnt = '0;
      next_first = 1'b1;
      next_oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      next_st = SCR_ST_IDLE;
      next_oe_n = 1'b1;
    end
    else
    begin
      case (st)
        SCR_ST_IDLE: next_oe_n = 1'b1;
        SCR_ST_ADDR, SCR_ST_WBYTE:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_bcnt = bcnt + 4'h1;
          end
          else if (scl_fall && bcnt == SCR_BITS_PER_BYTE)
          begin
            next_oe_n = 1'b0;
            if (st == SCR_ST_ADDR)
            begin
              next_rd_mode = shreg[0];
              if (shreg[7:1] == SCR_DEV_ADDR)
                next_st = SCR_ST_AACK;
              else
              begin
                next_st = SCR_ST_IDLE;
                next_oe_n = 1'b1;
              end
            end
            else
            begin
              next_st = SCR_ST_WACK;
              if (first)
              begin
                next_ptr = shreg;
                next_first = 1'b0;
              end
              else
              begin
                wr_pulse = 1'b1;
                next_ptr = ptr + 8'h01;
              end
            end
          end
        end
        SCR_ST_AACK, SCR_ST_WACK:
        begin
          if (scl_fall)
          begin
            next_bcnt = '0;
            if (st == SCR_ST_AACK && rd_mode)
            begin
              next_st = SCR_ST_RBYTE;
              next_txb = rd_data;
              next_oe_n = rd_data[7];
            end
            else
            begin
              next_st = SCR_ST_WBYTE;
              next_oe_n = 1'b1;
            end
          end
        end
        SCR_ST_RBYTE:
        begin
          if (scl_rise)
            next_bcnt = bcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bcnt == SCR_BITS_PER_BYTE)
            begin
              next_st = SCR_ST_RACK;
              next_oe_n = 1'b1;
            end
            else
            begin
              next_txb = {txb[6:0], 1'b0};
              next_oe_n = txb[6];
            end
          end
        end
        SCR_ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
              next_st = SCR_ST_IDLE;
            else
            begin
              next_cont = 1'b1;
              next_ptr = ptr + 8'h01;
            end
          end
          else if (scl_fall && cont)
          begin
            next_cont = 1'b0;
            next_st = SCR_ST_RBYTE;
            next_bcnt = '0;
            next_txb = rd_data;
            next_oe_n = rd_data[7];
          end
        end
        default:
        begin
          next_st = SCR_ST_IDLE;
          next_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st <= SCR_ST_IDLE;
      bcnt <= '0;
      shreg <= SCR_RST_BYTE;
      txb <= SCR_RST_BYTE;
      ptr <= SCR_RST_BYTE;
      first <= 1'b1;
      rd_mode <= 1'b0;
      cont <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
      p_scl <= 1'b0;
      p_sda <= 1'b0;
    end
    else
    begin
      st <= next_st;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      txb <= next_txb;
      ptr <= next_ptr;
      first <= next_first;
      rd_mode <= next_rd_mode;
      cont <= next_cont;
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
      p_scl <= scl_s;
      p_sda <= sda_s;
    end
  end

  // Writes to any address outside the three decoded ones fall through untouched.
  always_comb
  begin
    next_general_output_values = general_output_values;
    next_ovr = ovr;
    next_lvl = lvl;
    next_nrzi_bit = nrzi_bit;
    next_dv_off = dv_off;
    if (wr_pulse)
    begin
      case (ptr)
        SCR_ADDR_GPOUT: next_general_output_values = shreg[SCR_GP_W-1:0];
        SCR_ADDR_EMPH:
        begin
          next_ovr = shreg[SCR_BIT_OVERRIDE];
          next_lvl = scr_emph_e'(shreg[SCR_LVL_LSB +: SCR_LVL_W]);
        end
        SCR_ADDR_LINE:
        begin
          next_nrzi_bit = shreg[SCR_BIT_NRZI];
          next_dv_off = shreg[SCR_BIT_DVOFF];
        end
        default: next_ovr = ovr;
      endcase
    end
    // Pins are re-read every cycle so a strap change takes effect without software while the override bit is clear.
    next_cfg.emph_level = ovr ? lvl : scr_emph_e'(emph_pin_s);
    next_cfg.nrzi_en = ovr ? nrzi_bit : line_pin_s;
    next_cfg.valid_marker_on = !dv_off;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      general_output_values <= '0;
      ovr <= 1'b0;
      lvl <= SCR_EMPH_NONE;
      nrzi_bit <= 1'b0;
      dv_off <= 1'b0;
      cfg_out <= SCR_CFG_RST;
    end
    else
    begin
      general_output_values <= next_general_output_values;
      ovr <= next_ovr;
      lvl <= next_lvl;
      nrzi_bit <= next_nrzi_bit;
      dv_off <= next_dv_off;
      cfg_out <= next_cfg;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_gp_write_lands: assert property ((wr_pulse && ptr == SCR_ADDR_GPOUT) |=>
    general_output_values == $past(shreg[SCR_GP_W-1:0])) else $error("general_output_values missed write");
  a_emph_from_reg: assert property (ovr ##1 ovr |->
    cfg_out.emph_level == $past(lvl)) else $error("override level not applied");
  a_emph_from_pin: assert property ((!ovr) |=>
    cfg_out.emph_level == $past(emph_pin_s)) else $error("pin level not applied");
  a_level_code_map: assert property ((wr_pulse && ptr == SCR_ADDR_EMPH) |=> ##1
    (!ovr || cfg_out.emph_level == $past(shreg[SCR_LVL_LSB +: SCR_LVL_W], 2)))
    else $error("level code wrong");
  a_nrzi_gated: assert property ((!ovr && !line_pin_s && nrzi_bit) |=>
    !cfg_out.nrzi_en) else $error("line coding active without override");
  a_valid_off: assert property ((wr_pulse && ptr == SCR_ADDR_LINE) |=> ##1
    cfg_out.valid_marker_on == !$past(shreg[SCR_BIT_DVOFF], 2)) else $error("dv off wrong");
  a_rsv_reads_zero: assert property (is_reserved(ptr) |->
    rd_data == SCR_RST_BYTE) else $error("reserved read nonzero");
  a_rsv_write_kept: assert property ((wr_pulse && is_reserved(ptr)) |=>
    $stable(general_output_values) && $stable(ovr) && $stable(lvl) && $stable(dv_off))
    else $error("reserved write changed state");

  c_emph_write: cover property (wr_pulse && ptr == SCR_ADDR_EMPH);
  c_read_byte: cover property (st == SCR_ST_RACK && scl_rise);
  c_nrzi_on: cover property (ovr && cfg_out.nrzi_en);
  c_valid_off: cover property (!cfg_out.valid_marker_on);

endmodule
`default_nettype wire

// file: logic/scr_pkg.sv
`default_nettype none
package scr_pkg;

  // Register map of the slice held here.
  localparam logic [7:0] SCR_ADDR_GPOUT = 8'h06;
  localparam logic [7:0] SCR_ADDR_RSV_LO = 8'h07;
  localparam logic [7:0] SCR_ADDR_RSV_HI = 8'h1F;
  localparam logic [7:0] SCR_ADDR_EMPH = 8'h20;
  localparam logic [7:0] SCR_ADDR_LINE = 8'h21;

  // Field layout.
  localparam int SCR_GP_W = 3;
  localparam int SCR_BIT_OVERRIDE = 2;
  localparam int SCR_LVL_LSB = 0;
  localparam int SCR_LVL_W = 2;
  localparam int SCR_BIT_NRZI = 7;
  localparam int SCR_BIT_DVOFF = 6;

  // Reset value and bits per byte.
  localparam logic [7:0] SCR_RST_BYTE = 8'h00;
  localparam logic [3:0] SCR_BITS_PER_BYTE = 4'h8;

  // Management bus slave address; the value is arbitrary.
  localparam logic [6:0] SCR_DEV_ADDR = 7'h2A;

  typedef enum logic [1:0]
  {
    SCR_EMPH_NONE = 2'h0,
    SCR_EMPH_LOW  = 2'h1,
    SCR_EMPH_MED  = 2'h2,
    SCR_EMPH_HIGH = 2'h3
  } scr_emph_e;

  typedef enum logic [6:0]
  {
    SCR_ST_IDLE  = 7'h01,
    SCR_ST_ADDR  = 7'h02,
    SCR_ST_AACK  = 7'h04,
    SCR_ST_WBYTE = 7'h08,
    SCR_ST_WACK  = 7'h10,
    SCR_ST_RBYTE = 7'h20,
    SCR_ST_RACK  = 7'h40
  } scr_st_e;

  typedef struct packed
  {
    scr_emph_e emph_level;
    logic      nrzi_en;
    logic      valid_marker_on;
  } scr_cfg_s;

  localparam scr_cfg_s SCR_CFG_RST = '{SCR_EMPH_NONE, 1'b0, 1'b1};

endpackage
`default_nettype wire

// file: logic/scr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scr_sync
  import scr_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // Only the second stage is visible outside, to keep metastability contained.
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb
  begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire
